// ===== core/t16_core.sv
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
// Behaviour
// - Count of 0x0000 is the count floor.
// - Count of 0xFFFF (65535) is the absolute maximum.
// - Upper limit is the highest count; fixed maximum, match value A or snapshot.
// - Upper limit source by mode: match A, snapshot, or fixed constant.
// - No clock source selected means no ticks, counter holds.
// - Tick comes from system clock, prescaler or external pin with chosen edge.
// - Both double-buffered match values compared with count continuously.
// - Match with A or B sets its match flag.
// - All flags in one register, each request gated by its mask bit.
// - Capture event from pin or comparator, optional filter, copies count.
// - Match A as limit in pulse-width mode drives no output A.
// - Match A as pulse-width limit is double buffered.
// - Three 8-bit control registers, plain read and write.
// - One shared 8-bit high-byte holding register for all 16-bit values.
// - Low-byte write loads holding byte and written byte together.
// - Low-byte read of count or snapshot copies high byte into holding register.
// - High byte of match values reads directly, holding untouched.
// - Counter high-byte location always reaches the holding register.
// - Software write to counter beats clear or count same cycle.
module t16_core #(
	parameter int PRE_W = 10,
	parameter int NC_LEN = 4
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	input wire t16_pkg::t16_bus_t i_bus,
	input wire logic i_ext_tick_pin,
	input wire logic i_snap_trig_pin,
	input wire logic i_cmp_out,
	output logic [t16_pkg::DATA_W-1:0] o_rdata,
	output logic o_wave_out_a,
	output logic o_wave_out_b,
	output logic [t16_pkg::FLG_W-1:0] o_irq_req
);
	import t16_pkg::*;

	// ------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------
	if (PRE_W < TAP_DIV1024) begin : g_bad_pre
		$error("PRE_W too small for the largest prescaler tap");
	end
	if (NC_LEN < 2) begin : g_bad_nc
		$error("NC_LEN must be at least 2");
	end

	// Low-bits-all-ones test, shared by every prescaler tap
	function automatic logic tap_hit(input logic [PRE_W-1:0] v, input int n);
		logic r;
		r = 1'b1;
		for (int i = 0; i < n; i++) begin
			r = r & v[i];
		end
		return r;
	endfunction : tap_hit

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0] ctrl_a_r, ctrl_b_r, ctrl_c_r, mask_r, hold_r, hold_nxt;
	logic [15:0] cnt_r, cnt_nxt, ma_buf_r, ma_act_r, mb_buf_r, mb_act_r;
	logic [15:0] snap_r, snap_nxt;
	logic [FLG_W-1:0] flag_r, flag_nxt;
	logic [PRE_W-1:0] pre_r;
	logic ext_prev_r;
	logic [NC_LEN-1:0] nc_hist_r;
	logic cap_lvl_r, cap_prev_r;
	logic [7:0] rd_mux;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	wire wr_cnt_lo = i_bus.wr && i_bus.addr == OFS_CNT_LO;
	wire wr_ma_lo = i_bus.wr && i_bus.addr == OFS_MA_LO;
	wire wr_mb_lo = i_bus.wr && i_bus.addr == OFS_MB_LO;
	wire wr_snap_lo = i_bus.wr && i_bus.addr == OFS_SNAP_LO;
	wire wr_flag = i_bus.wr && i_bus.addr == OFS_FLAG;
	// Every high-byte location lands in the one holding register
	wire wr_any_hi = i_bus.wr && (i_bus.addr == OFS_CNT_HI || i_bus.addr == OFS_MA_HI ||
		i_bus.addr == OFS_MB_HI || i_bus.addr == OFS_SNAP_HI);
	wire rd_cnt_lo = i_bus.rd && i_bus.addr == OFS_CNT_LO;
	wire rd_snap_lo = i_bus.rd && i_bus.addr == OFS_SNAP_LO;
	wire [15:0] wr_word = {hold_r, i_bus.wdata};

	// ------------------------------------------------------------
	// Tick source selection
	// ------------------------------------------------------------
	t16_clksel_t cs;
	t16_topsel_t topsel;
	assign cs = t16_clksel_t'(ctrl_b_r[CS_LSB +: 3]);
	assign topsel = t16_topsel_t'(ctrl_a_r[TOPSEL_LSB +: 2]);
	wire ext_rise = i_ext_tick_pin && !ext_prev_r;
	wire ext_fall = !i_ext_tick_pin && ext_prev_r;
	logic tick;
	// Off selects no source at all, so the counter cannot move
	always_comb begin
		unique case (cs)
			CS_OFF: tick = 1'b0;
			CS_SYS: tick = 1'b1;
			CS_DIV8: tick = tap_hit(pre_r, TAP_DIV8);
			CS_DIV64: tick = tap_hit(pre_r, TAP_DIV64);
			CS_DIV256: tick = tap_hit(pre_r, TAP_DIV256);
			CS_DIV1024: tick = tap_hit(pre_r, TAP_DIV1024);
			CS_EXT_FALL: tick = ext_fall;
			CS_EXT_RISE: tick = ext_rise;
		endcase
	end

	// ------------------------------------------------------------
	// Limits and compare
	// ------------------------------------------------------------
	logic [15:0] top_val;
	always_comb begin
		unique case (topsel)
			TOP_MAX: top_val = COUNT_MAX;
			TOP_MATCH_A: top_val = ma_act_r;
			TOP_SNAP: top_val = snap_r;
			TOP_PWM_A: top_val = ma_act_r;
		endcase
	end
	wire at_top = cnt_r == top_val;
	wire at_floor = cnt_r == COUNT_FLOOR;
	wire top_tick = tick && at_top;
	// Compares run every cycle; flags only take them on a tick
	wire hit_a = cnt_r == ma_act_r;
	wire hit_b = cnt_r == mb_act_r;
	wire pwm_buf = topsel == TOP_PWM_A;

	// Counter: a bus write overrides the wrap or the increment
	always_comb begin
		cnt_nxt = cnt_r;
		if (wr_cnt_lo) begin
			cnt_nxt = wr_word;
		end else if (top_tick) begin
			cnt_nxt = COUNT_FLOOR;
		end else if (tick) begin
			cnt_nxt = cnt_r + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// Capture path: source mux, optional filter, edge detect
	// ------------------------------------------------------------
	wire cap_src = ctrl_b_r[CAP_SRC_BIT] ? i_cmp_out : i_snap_trig_pin;
	wire nc_all_hi = &nc_hist_r;
	wire nc_all_lo = ~|nc_hist_r;
	wire cap_lvl_nxt = !ctrl_b_r[NC_EN_BIT] ? cap_src :
		(nc_all_hi ? 1'b1 : (nc_all_lo ? 1'b0 : cap_lvl_r));
	wire cap_edge = ctrl_b_r[CAP_EDGE_BIT] ? (cap_lvl_r && !cap_prev_r) :
		(!cap_lvl_r && cap_prev_r);
	// Snapshot is the limit in that mode, so capture is shut off there
	wire cap_evt = cap_edge && topsel != TOP_SNAP;

	always_comb begin
		snap_nxt = snap_r;
		if (wr_snap_lo && topsel == TOP_SNAP) begin
			snap_nxt = wr_word;
		end else if (cap_evt) begin
			snap_nxt = cnt_r;
		end
	end

	// Sticky flags: a set in the same cycle as a clear wins
	wire [FLG_W-1:0] flag_set = {cap_evt, tick && hit_b, tick && hit_a, top_tick};
	wire [FLG_W-1:0] flag_clr = wr_flag ? i_bus.wdata[FLG_W-1:0] : '0;
	assign flag_nxt = (flag_r & ~flag_clr) | flag_set;

	// Holding register: high writes load it, low reads of count and snapshot refresh it
	always_comb begin
		hold_nxt = hold_r;
		if (wr_any_hi) begin
			hold_nxt = i_bus.wdata;
		end else if (rd_cnt_lo) begin
			hold_nxt = cnt_r[15:8];
		end else if (rd_snap_lo) begin
			hold_nxt = snap_r[15:8];
		end
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	always_comb begin
		unique case (i_bus.addr)
			OFS_CTRL_A: rd_mux = ctrl_a_r;
			OFS_CTRL_B: rd_mux = ctrl_b_r;
			OFS_CTRL_C: rd_mux = ctrl_c_r;
			OFS_CNT_LO: rd_mux = cnt_r[7:0];
			OFS_CNT_HI: rd_mux = hold_r;
			OFS_MA_LO: rd_mux = ma_buf_r[7:0];
			OFS_MA_HI: rd_mux = ma_buf_r[15:8];
			OFS_MB_LO: rd_mux = mb_buf_r[7:0];
			OFS_MB_HI: rd_mux = mb_buf_r[15:8];
			OFS_SNAP_LO: rd_mux = snap_r[7:0];
			OFS_SNAP_HI: rd_mux = hold_r;
			OFS_FLAG: rd_mux = {{(8 - FLG_W){1'b0}}, flag_r};
			OFS_MASK: rd_mux = mask_r;
			default: rd_mux = RST_BYTE;
		endcase
	end

	// ------------------------------------------------------------
	// Control registers and bus-side state
	// ------------------------------------------------------------
	// Plain byte registers, no ordering restriction
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ctrl_a_r <= RST_BYTE;
			ctrl_b_r <= RST_BYTE;
			ctrl_c_r <= RST_BYTE;
			mask_r <= RST_BYTE;
		end else if (i_ce && i_bus.wr) begin
			if (i_bus.addr == OFS_CTRL_A) ctrl_a_r <= i_bus.wdata;
			if (i_bus.addr == OFS_CTRL_B) ctrl_b_r <= i_bus.wdata;
			if (i_bus.addr == OFS_CTRL_C) ctrl_c_r <= i_bus.wdata;
			if (i_bus.addr == OFS_MASK) mask_r <= i_bus.wdata;
		end
	end

	// Match buffers; active copies follow one cycle later except in buffered mode
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ma_buf_r <= RST_WORD;
			mb_buf_r <= RST_WORD;
			ma_act_r <= RST_WORD;
			mb_act_r <= RST_WORD;
		end else if (i_ce) begin
			if (wr_ma_lo) ma_buf_r <= wr_word;
			if (wr_mb_lo) mb_buf_r <= wr_word;
			if (!pwm_buf || top_tick) begin
				ma_act_r <= ma_buf_r;
				mb_act_r <= mb_buf_r;
			end
		end
	end

	// Counter, snapshot, flags and holding byte
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cnt_r <= RST_WORD;
			snap_r <= RST_WORD;
			flag_r <= '0;
			hold_r <= RST_BYTE;
		end else if (i_ce) begin
			cnt_r <= cnt_nxt;
			snap_r <= snap_nxt;
			flag_r <= flag_nxt;
			hold_r <= hold_nxt;
		end
	end

	// Prescaler and input history; prescaler free-runs to keep taps cheap
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			pre_r <= '0;
			ext_prev_r <= 1'b0;
			nc_hist_r <= '0;
			cap_lvl_r <= 1'b0;
			cap_prev_r <= 1'b0;
		end else if (i_ce) begin
			pre_r <= pre_r + PRE_W'(1);
			ext_prev_r <= i_ext_tick_pin;
			nc_hist_r <= {nc_hist_r[NC_LEN-2:0], cap_src};
			cap_lvl_r <= cap_lvl_nxt;
			cap_prev_r <= cap_lvl_r;
		end
	end

	// ------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------
	// Read data stand only in the cycle after the strobe
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_rdata <= RST_BYTE;
			o_wave_out_a <= 1'b0;
			o_wave_out_b <= 1'b0;
			o_irq_req <= '0;
		end else if (i_ce) begin
			o_rdata <= i_bus.rd ? rd_mux : RST_BYTE;
			o_wave_out_a <= !pwm_buf && (cnt_r < ma_act_r);
			o_wave_out_b <= cnt_r < mb_act_r;
			o_irq_req <= flag_r & mask_r[FLG_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	a_floor_wrap: assert property (i_ce && top_tick && !wr_cnt_lo |=> at_floor)
		else $error("count did not wrap to floor at limit");
	a_max_limit: assert property (i_ce && tick && topsel == TOP_MAX
		&& cnt_r == COUNT_MAX && !wr_cnt_lo |=> cnt_r == COUNT_FLOOR && flag_r[FLG_OVF])
		else $error("maximum did not wrap with overflow flag");
	a_stop_hold: assert property (i_ce && cs == CS_OFF && !wr_cnt_lo |=> $stable(cnt_r))
		else $error("counter moved with no clock source");
	a_write_wins: assert property (i_ce && wr_cnt_lo && tick
		|=> cnt_r == {$past(hold_r), $past(i_bus.wdata)})
		else $error("counter write lost to count");
	a_match_flag: assert property (i_ce && tick && hit_b |=> flag_r[FLG_MB])
		else $error("match B flag not set");
	a_irq_gate: assert property (i_ce && flag_r[FLG_MA] && !mask_r[FLG_MA]
		|=> !o_irq_req[FLG_MA])
		else $error("masked request reached output");
	a_capture_copy: assert property (i_ce && cap_evt && !wr_snap_lo
		|=> snap_r == $past(cnt_r) && flag_r[FLG_CAP])
		else $error("capture did not copy count");
	a_pwm_a_quiet: assert property (i_ce && pwm_buf |=> !o_wave_out_a)
		else $error("output A driven while A is the limit");
	a_buf_hold: assert property (i_ce && pwm_buf && wr_ma_lo && !top_tick
		|=> $stable(ma_act_r))
		else $error("buffered limit changed mid-period");
	a_low_read_hold: assert property (i_ce && rd_cnt_lo
		|=> hold_r == $past(cnt_r[15:8]) ##1 (i_ce && i_bus.rd && i_bus.addr == OFS_CNT_HI
		&& !$past(wr_any_hi || i_bus.rd)) |=> o_rdata == $past(cnt_r[15:8], 3))
		else $error("holding byte not refreshed by low read");
	a_ma_hi_direct: assert property (i_ce && i_bus.rd && i_bus.addr == OFS_MA_HI
		|=> o_rdata == $past(ma_buf_r[15:8]) && $stable(hold_r))
		else $error("match high byte read touched holding byte");

	c_top_wrap: cover property (i_ce && top_tick ##1 at_floor);
	c_capture: cover property (i_ce && cap_evt);
	c_word_write: cover property (i_ce && wr_any_hi ##1 i_ce && wr_cnt_lo);
	c_word_read: cover property (i_ce && rd_cnt_lo ##1 i_ce && i_bus.rd && i_bus.addr == OFS_CNT_HI);
endmodule : t16_core

// ===== core/t16_pkg.sv
package t16_pkg;
	// ------------------------------------------------------------
	// Register map, byte-wide data bus
	// ------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [3:0] OFS_CTRL_A = 4'h0;
	localparam logic [3:0] OFS_CTRL_B = 4'h1;
	localparam logic [3:0] OFS_CTRL_C = 4'h2;
	localparam logic [3:0] OFS_CNT_LO = 4'h4;
	localparam logic [3:0] OFS_CNT_HI = 4'h5;
	localparam logic [3:0] OFS_MA_LO = 4'h6;
	localparam logic [3:0] OFS_MA_HI = 4'h7;
	localparam logic [3:0] OFS_MB_LO = 4'h8;
	localparam logic [3:0] OFS_MB_HI = 4'h9;
	localparam logic [3:0] OFS_SNAP_LO = 4'hA;
	localparam logic [3:0] OFS_SNAP_HI = 4'hB;
	localparam logic [3:0] OFS_FLAG = 4'hC;
	localparam logic [3:0] OFS_MASK = 4'hD;
	// ------------------------------------------------------------
	// Reset values and count limits
	// ------------------------------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [15:0] COUNT_FLOOR = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int TOPSEL_LSB = 0;
	localparam int CS_LSB = 0;
	localparam int CAP_SRC_BIT = 3;
	localparam int CAP_EDGE_BIT = 4;
	localparam int NC_EN_BIT = 5;
	localparam int FLG_OVF = 0;
	localparam int FLG_MA = 1;
	localparam int FLG_MB = 2;
	localparam int FLG_CAP = 3;
	localparam int FLG_W = 4;
	// Prescaler tap widths: divide by 8, 64, 256, 1024
	localparam int TAP_DIV8 = 3;
	localparam int TAP_DIV64 = 6;
	localparam int TAP_DIV256 = 8;
	localparam int TAP_DIV1024 = 10;
	// ------------------------------------------------------------
	// Enumerations and carriers
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		CS_OFF = 3'h0, CS_SYS = 3'h1, CS_DIV8 = 3'h2, CS_DIV64 = 3'h3,
		CS_DIV256 = 3'h4, CS_DIV1024 = 3'h5, CS_EXT_FALL = 3'h6, CS_EXT_RISE = 3'h7
	} t16_clksel_t;
	typedef enum logic [1:0] {
		TOP_MAX = 2'h0, TOP_MATCH_A = 2'h1, TOP_SNAP = 2'h2, TOP_PWM_A = 2'h3
	} t16_topsel_t;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} t16_bus_t;
endpackage : t16_pkg

// ===== testbench/t16_cpu_model.sv
`timescale 1ns/1ps
module t16_cpu_model (
	input wire logic i_clk,
	input wire logic [t16_pkg::DATA_W-1:0] i_rdata,
	output t16_pkg::t16_bus_t o_bus
);
	import t16_pkg::*;
	// ----
	// Byte cycles, launched just after a rising edge
	// ----
	initial begin
		o_bus = '0;
	end
	// One-cycle write; data inverted after release so stale bytes never look valid
	task automatic wr8(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_bus.addr <= a;
		o_bus.wdata <= d;
		o_bus.wr <= 1'b1;
		@(posedge i_clk);
		o_bus.wr <= 1'b0;
		o_bus.wdata <= ~d;
	endtask : wr8
	// Read data stand only in the cycle after the strobe
	task automatic rd8(input logic [3:0] a, output logic [7:0] d);
		@(posedge i_clk);
		o_bus.addr <= a;
		o_bus.rd <= 1'b1;
		@(posedge i_clk);
		o_bus.rd <= 1'b0;
		#1;
		d = i_rdata;
	endtask : rd8
	// ----
	// Word access; no interrupt context here, so each pair is atomic
	// ----
	task automatic wr16(input logic [3:0] a, input logic [15:0] v);
		wr8(a + 4'h1, v[15:8]);
		wr8(a, v[7:0]);
	endtask : wr16
	task automatic rd16(input logic [3:0] a, output logic [15:0] v);
		rd8(a, v[7:0]);
		rd8(a + 4'h1, v[15:8]);
	endtask : rd16
endmodule : t16_cpu_model

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import t16_pkg::*;
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	logic ext_pin = 1'b0;
	logic snap_pin = 1'b0;
	logic cmp_out = 1'b0;
	t16_bus_t bus;
	logic [7:0] rdata;
	logic wave_a;
	logic wave_b;
	logic [3:0] irq;
	logic [15:0] w;
	logic [7:0] b;
	int mismatches = 0;
	int compares = 0;
	// ----
	// Clock, design and bus master
	// ----
	initial begin
		forever #4 i_clk = ~i_clk;
	end
	t16_core i_t16_core (.i_clk(i_clk), .i_srst(i_srst), .i_ce(1'b1), .i_bus(bus),
		.i_ext_tick_pin(ext_pin), .i_snap_trig_pin(snap_pin), .i_cmp_out(cmp_out),
		.o_rdata(rdata), .o_wave_out_a(wave_a), .o_wave_out_b(wave_b), .o_irq_req(irq));
	t16_cpu_model i_t16_cpu_model (.i_clk(i_clk), .i_rdata(rdata), .o_bus(bus));
	// ----
	// Shared helpers
	// ----
	task automatic wr8(input logic [3:0] a, input logic [7:0] d);
		i_t16_cpu_model.wr8(a, d);
	endtask : wr8
	task automatic rd8(input logic [3:0] a, output logic [7:0] d);
		i_t16_cpu_model.rd8(a, d);
	endtask : rd8
	task automatic wr16(input logic [3:0] a, input logic [15:0] v);
		i_t16_cpu_model.wr16(a, v);
	endtask : wr16
	task automatic rd16(input logic [3:0] a, output logic [15:0] v);
		i_t16_cpu_model.rd16(a, v);
	endtask : rd16
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop
	// Bounded wait on one request line; a hang ends the run
	task automatic wait_irq(input int k);
		int n;
		n = 0;
		while (irq[k] !== 1'b1 && n < 3000) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		if (n >= 3000) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, irq[k], 1'b1);
			report_and_stop();
		end
	endtask : wait_irq
	// ----
	// Scenarios
	// ----
	task automatic t_regs;
		rd8(OFS_FLAG, b);
		chk(b, 16'h0);
		rd8(4'h3, b);
		chk(b, 16'h0);
		wr8(OFS_CTRL_C, 8'hA5);
		wr8(OFS_CTRL_A, 8'h5A);
		rd8(OFS_CTRL_C, b);
		chk(b, 16'hA5);
		rd8(OFS_CTRL_A, b);
		chk(b, 16'h5A);
		wr8(OFS_CTRL_A, 8'h00);
		$display("test regs done");
	endtask : t_regs
	// High write only lands in the holding byte, never the counter
	task automatic t_cnt;
		wr16(OFS_CNT_LO, 16'h01FF);
		rd16(OFS_CNT_LO, w);
		chk(w, 16'h01FF);
		wr8(OFS_CNT_HI, 8'h7E);
		rd16(OFS_CNT_LO, w);
		chk(w, 16'h01FF);
		$display("test count word done");
	endtask : t_cnt
	task automatic t_shared;
		wr16(OFS_MA_LO, 16'h1234);
		rd8(OFS_CNT_LO, b);
		wr8(OFS_MB_LO, 8'h56);
		rd16(OFS_MB_LO, w);
		chk(w, 16'h0156);
		rd8(OFS_MA_HI, b);
		chk(b, 16'h12);
		rd8(OFS_CNT_HI, b);
		chk(b, 16'h01);
		wr8(OFS_MA_HI, 8'h3C);
		wr8(OFS_MA_LO, 8'h11);
		wr8(OFS_MB_LO, 8'h22);
		rd16(OFS_MA_LO, w);
		chk(w, 16'h3C11);
		rd16(OFS_MB_LO, w);
		chk(w, 16'h3C22);
		$display("test shared hold done");
	endtask : t_shared
	task automatic t_match;
		wr16(OFS_MA_LO, 16'h0040);
		wr16(OFS_MB_LO, 16'h0080);
		wr8(OFS_MASK, 8'h02);
		wr16(OFS_CNT_LO, 16'h0);
		wr8(OFS_CTRL_B, 8'(CS_SYS));
		chk({wave_a, wave_b}, 16'h3);
		wait_irq(FLG_MA);
		chk(irq, 16'h2);
		chk(wave_b, 16'h1);
		chk(wave_a, 16'h0);
		wr8(OFS_CTRL_B, 8'h00);
		rd8(OFS_FLAG, b);
		chk(b, 16'h02);
		wr8(OFS_FLAG, 8'h02);
		rd8(OFS_FLAG, b);
		chk({b, 4'h0, irq}, 16'h0);
		$display("test match done");
	endtask : t_match
	// Writes land while the count runs at full rate
	task automatic t_wrap;
		wr8(OFS_CTRL_B, 8'(CS_SYS));
		wr16(OFS_CNT_LO, 16'h8000);
		rd16(OFS_CNT_LO, w);
		chk(w & 16'hFFF0, 16'h8000);
		wr8(OFS_MASK, 8'h01);
		wr16(OFS_CNT_LO, 16'hFFF0);
		wait_irq(FLG_OVF);
		rd16(OFS_CNT_LO, w);
		chk(w & 16'hFFF0, 16'h0);
		wr8(OFS_CTRL_B, 8'h00);
		wr8(OFS_FLAG, 8'h0F);
		$display("test wrap done");
	endtask : t_wrap
	task automatic t_limit;
		logic [15:0] lim [4] = '{16'h0, 16'h8, 16'h6, 16'h20};
		for (int m = 1; m < 4; m++) begin
			wr8(OFS_CTRL_B, 8'h00);
			wr8(OFS_CTRL_A, 8'(m));
			wr16(m == 2 ? OFS_SNAP_LO : OFS_MA_LO, lim[m]);
			wr16(OFS_CNT_LO, 16'h0);
			wr8(OFS_CTRL_B, 8'(CS_SYS));
			repeat (12) begin
				rd16(OFS_CNT_LO, w);
				chk(w <= lim[m], 16'h1);
				chk(wave_a & (m == 3), 16'h0);
			end
		end
		wr8(OFS_CTRL_B, 8'h00);
		wr8(OFS_CTRL_A, 8'h00);
		wr8(OFS_FLAG, 8'h0F);
		$display("test limit done");
	endtask : t_limit
	// Pin rising, comparator rising, filtered pin falling
	task automatic t_capture;
		logic [7:0] ctl [3] = '{8'h10, 8'h18, 8'h20};
		for (int s = 0; s < 3; s++) begin
			wr16(OFS_CNT_LO, 16'h0A00 + 16'(s));
			wr8(OFS_CTRL_B, ctl[s]);
			@(posedge i_clk);
			if (s == 1) begin
				cmp_out <= 1'b1;
			end else begin
				snap_pin <= ~snap_pin;
			end
			repeat (10) @(posedge i_clk);
			rd16(OFS_SNAP_LO, w);
			chk(w, 16'h0A00 + 16'(s));
			rd8(OFS_FLAG, b);
			chk(b[FLG_CAP], 16'h1);
			wr8(OFS_FLAG, 8'h0F);
		end
		$display("test capture done");
	endtask : t_capture
	// Off, falling and rising external edges; five pulses each
	task automatic t_ext;
		logic [7:0] cs [3] = '{8'h00, 8'h06, 8'h07};
		for (int k = 0; k < 3; k++) begin
			wr16(OFS_CNT_LO, 16'h0);
			wr8(OFS_CTRL_B, cs[k]);
			repeat (5) begin
				repeat (3) @(posedge i_clk);
				ext_pin <= 1'b1;
				repeat (3) @(posedge i_clk);
				ext_pin <= 1'b0;
			end
			repeat (3) @(posedge i_clk);
			wr8(OFS_CTRL_B, 8'h00);
			rd16(OFS_CNT_LO, w);
			chk(w, k ? 16'h5 : 16'h0);
		end
		$display("test external tick done");
	endtask : t_ext
	// Prescaler taps: a window of ten tap periods gives ten ticks whatever the phase
	task automatic t_pre;
		int tap [4] = '{TAP_DIV8, TAP_DIV64, TAP_DIV256, TAP_DIV1024};
		for (int j = 0; j < 4; j++) begin
			wr16(OFS_CNT_LO, 16'h0);
			wr8(OFS_CTRL_B, 8'(CS_DIV8) + 8'(j));
			repeat ((10 << tap[j]) - 2) @(posedge i_clk);
			wr8(OFS_CTRL_B, 8'h00);
			rd16(OFS_CNT_LO, w);
			chk(w, 16'hA);
		end
		$display("test prescaler done");
	endtask : t_pre
	// Main sequence
	initial begin
		repeat (8) @(posedge i_clk);
		i_srst <= 1'b0;
		t_regs();
		t_cnt();
		t_shared();
		t_match();
		t_wrap();
		t_limit();
		t_capture();
		t_ext();
		t_pre();
		report_and_stop();
	end
endmodule : tb_top
